// File: hw/shuic_pkg.sv
package shuic_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] SHUIC_OFF_GUARD_HALT_MOVE = 8'h71;
  localparam logic [7:0] SHUIC_OFF_QR_THRESH       = 8'h72;
  localparam logic [7:0] SHUIC_OFF_GUARD_FHALT     = 8'h73;
  localparam logic [7:0] SHUIC_OFF_GUARD_PROX      = 8'h74;
  localparam logic [7:0] SHUIC_OFF_QR_HALT_TIME    = 8'h75;
  localparam logic [7:0] SHUIC_OFF_HYST_SELECT     = 8'h80;
  localparam logic [7:0] SHUIC_OFF_HYST_FHALT      = 8'h81;
  localparam logic [7:0] SHUIC_OFF_HYST_PROX       = 8'h82;
  localparam logic [7:0] SHUIC_OFF_HYST_TOUCH      = 8'h83;
  // ==========================================================
  // Reset values
  localparam logic [7:0] SHUIC_RST_GUARD_HALT_MOVE = 8'h25;
  localparam logic [7:0] SHUIC_RST_QR_THRESH       = 8'h05;
  localparam logic [7:0] SHUIC_RST_GUARD_FHALT     = 8'h16;
  localparam logic [7:0] SHUIC_RST_GUARD_PROX      = 8'h25;
  localparam logic [7:0] SHUIC_RST_QR_HALT_TIME    = 8'h28;
  localparam logic [7:0] SHUIC_RST_HYST_SELECT     = 8'hA2;
  localparam logic [7:0] SHUIC_RST_HYST_FHALT      = 8'h0A;
  localparam logic [7:0] SHUIC_RST_HYST_PROX       = 8'h16;
  localparam logic [7:0] SHUIC_RST_HYST_TOUCH      = 8'h25;
  // ==========================================================
  // Field layout
  localparam logic [7:0] SHUIC_HYST_WMASK          = 8'h33;
  localparam int         SHUIC_HALT_TO_LSB         = 4;
  localparam int         SHUIC_TOUCH_HYST_LSB      = 4;
  localparam int         SHUIC_PROX_HYST_LSB       = 0;
  localparam logic [7:0] SHUIC_QR_NEVER_EXPIRE     = 8'hFF;
  // ==========================================================
  // Timing
  localparam int         SHUIC_CLK_HZ              = 25_000_000;
  localparam int         SHUIC_STEP_MS             = 500;
  localparam int         SHUIC_STEP_CYCLES         =
    SHUIC_CLK_HZ / 1000 * SHUIC_STEP_MS;
  // ==========================================================
  // Hysteresis encodings
  typedef enum logic [1:0] {
    SHUIC_HYST_OFF = 2'b00,
    SHUIC_HYST_QTR = 2'b01,
    SHUIC_HYST_EGT = 2'b10,
    SHUIC_HYST_SXT = 2'b11
  } shuic_hyst_t;
endpackage : shuic_pkg

// File: hw/shuic_hyst_calc.sv
`timescale 1ns/1ps
module shuic_hyst_calc #(
  parameter int W = 10
) (
  // Threshold and selection
  input  wire logic [W-1:0]           thresh_i,
  input  wire shuic_pkg::shuic_hyst_t sel_i,
  // Band
  output logic      [W-1:0]           band_o
);
  import shuic_pkg::*;

  initial begin
    if (W < 4) begin
      $error("shuic_hyst_calc: width too small");
    end
  end

  // Fraction of threshold
  assign band_o = (sel_i == SHUIC_HYST_QTR) ? (thresh_i >> 2) :
                  (sel_i == SHUIC_HYST_EGT) ? (thresh_i >> 3) :
                  (sel_i == SHUIC_HYST_SXT) ? (thresh_i >> 4) :
                  '0;
endmodule : shuic_hyst_calc

// File: hw/shuic_regs.sv
`timescale 1ns/1ps
// Functional notes
// - First io pin is open drain, driven low when asserted.
// - 0x71 bits 7-4 set average halt timeout, 500ms units.
// - 0x71 bits 3-0 hold movement threshold, unscaled.
// - 0x72 holds 8-bit quick release threshold, unscaled.
// - Config bit 7 low and threshold zero: never enter timeout mode.
// - Config bit 7 high and threshold zero: timeout on guard prox.
// - 0x73 guard filter halt threshold; zero means always halt.
// - 0x74 channel zero prox threshold while guard active.
// - 0x75 quick release halt time in 500ms units.
// - Halt time 0xFF never expires.
// - 0x80 bits 5-4 select touch hysteresis fraction.
// - 0x80 bits 1-0 select prox hysteresis fraction.
// - 0x81 hysteresis filter halt threshold; zero always halts.
// - 0x82 hysteresis prox threshold, unscaled.
// - Hysteresis touch threshold is 0x83 value times four.
// - Guard active uses guard prox threshold, not general one.
// - Standoff select bit routes standoff or ready onto pin.
module shuic_regs #(
  parameter int STEP_CYCLES = shuic_pkg::SHUIC_STEP_CYCLES
) (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // Register port
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  output logic            reg_hit_o,
  // Engine context
  input  wire logic       guard_active_i,
  input  wire logic       guard_prox_i,
  input  wire logic       movement_i,
  input  wire logic       quick_release_i,
  input  wire logic       cfg_timeout_on_zero_i,
  input  wire logic       standoff_to_pin_i,
  input  wire logic       standoff_i,
  input  wire logic       ready_i,
  input  wire logic [7:0] channel_zero_prox_i,
  // Derived settings
  output logic      [7:0] prox_thresh_sel_o,
  output logic      [3:0] movement_thresh_o,
  output logic      [7:0] quick_release_thresh_o,
  output logic      [7:0] guard_filter_halt_o,
  output logic            guard_filter_always_o,
  output logic      [7:0] hyst_filter_halt_o,
  output logic            hyst_filter_always_o,
  output logic      [7:0] hyst_prox_thresh_o,
  output logic      [9:0] hyst_touch_thresh_o,
  output logic      [9:0] touch_hyst_band_o,
  output logic      [9:0] prox_hyst_band_o,
  output logic            timeout_mode_o,
  output logic            avg_halt_o,
  // First io pin
  output logic            first_io_pin_o,
  output logic            first_io_pin_oe_n_o
);
  import shuic_pkg::*;

  initial begin
    if (STEP_CYCLES < 1) begin
      $error("shuic_regs: STEP_CYCLES must be positive");
    end
  end

  // ==========================================================
  // Register file
  logic [7:0] halt_move_reg, qr_thr_reg, g_fhalt_reg, g_prox_reg;
  logic [7:0] qr_time_reg, hyst_sel_reg, h_fhalt_reg;
  logic [7:0] h_prox_reg, h_touch_reg;

  wire we_hm = reg_wr_i && reg_addr_i == SHUIC_OFF_GUARD_HALT_MOVE;
  wire we_qt = reg_wr_i && reg_addr_i == SHUIC_OFF_QR_THRESH;
  wire we_gf = reg_wr_i && reg_addr_i == SHUIC_OFF_GUARD_FHALT;
  wire we_gp = reg_wr_i && reg_addr_i == SHUIC_OFF_GUARD_PROX;
  wire we_qh = reg_wr_i && reg_addr_i == SHUIC_OFF_QR_HALT_TIME;
  wire we_hs = reg_wr_i && reg_addr_i == SHUIC_OFF_HYST_SELECT;
  wire we_hf = reg_wr_i && reg_addr_i == SHUIC_OFF_HYST_FHALT;
  wire we_hp = reg_wr_i && reg_addr_i == SHUIC_OFF_HYST_PROX;
  wire we_ht = reg_wr_i && reg_addr_i == SHUIC_OFF_HYST_TOUCH;

  wire [7:0] hyst_sel_next = (hyst_sel_reg & ~SHUIC_HYST_WMASK) |
                             (reg_wdata_i & SHUIC_HYST_WMASK);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      halt_move_reg <= SHUIC_RST_GUARD_HALT_MOVE;
      qr_thr_reg    <= SHUIC_RST_QR_THRESH;
      g_fhalt_reg   <= SHUIC_RST_GUARD_FHALT;
      g_prox_reg    <= SHUIC_RST_GUARD_PROX;
      qr_time_reg   <= SHUIC_RST_QR_HALT_TIME;
      hyst_sel_reg  <= SHUIC_RST_HYST_SELECT;
      h_fhalt_reg   <= SHUIC_RST_HYST_FHALT;
      h_prox_reg    <= SHUIC_RST_HYST_PROX;
      h_touch_reg   <= SHUIC_RST_HYST_TOUCH;
    end else begin
      if (we_hm) halt_move_reg <= reg_wdata_i;
      if (we_qt) qr_thr_reg    <= reg_wdata_i;
      if (we_gf) g_fhalt_reg   <= reg_wdata_i;
      if (we_gp) g_prox_reg    <= reg_wdata_i;
      if (we_qh) qr_time_reg   <= reg_wdata_i;
      if (we_hs) hyst_sel_reg  <= hyst_sel_next;
      if (we_hf) h_fhalt_reg   <= reg_wdata_i;
      if (we_hp) h_prox_reg    <= reg_wdata_i;
      if (we_ht) h_touch_reg   <= reg_wdata_i;
    end
  end

  // ==========================================================
  // Read decode
  function automatic logic [8:0] rd_sel(input logic [7:0] a);
    unique case (a)
      SHUIC_OFF_GUARD_HALT_MOVE: rd_sel = {1'b1, halt_move_reg};
      SHUIC_OFF_QR_THRESH:       rd_sel = {1'b1, qr_thr_reg};
      SHUIC_OFF_GUARD_FHALT:     rd_sel = {1'b1, g_fhalt_reg};
      SHUIC_OFF_GUARD_PROX:      rd_sel = {1'b1, g_prox_reg};
      SHUIC_OFF_QR_HALT_TIME:    rd_sel = {1'b1, qr_time_reg};
      SHUIC_OFF_HYST_SELECT:     rd_sel = {1'b1, hyst_sel_reg};
      SHUIC_OFF_HYST_FHALT:      rd_sel = {1'b1, h_fhalt_reg};
      SHUIC_OFF_HYST_PROX:       rd_sel = {1'b1, h_prox_reg};
      SHUIC_OFF_HYST_TOUCH:      rd_sel = {1'b1, h_touch_reg};
      default:                   rd_sel = 9'h000;
    endcase
  endfunction : rd_sel

  wire [8:0] rd_word = rd_sel(reg_addr_i);
  assign reg_hit_o = rd_word[8];

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_word[7:0];
    end
  end

  // ==========================================================
  // Threshold fields
  // Movement threshold
  assign movement_thresh_o      = halt_move_reg[3:0];
  assign quick_release_thresh_o = qr_thr_reg;
  assign guard_filter_halt_o    = g_fhalt_reg;
  assign guard_filter_always_o  = g_fhalt_reg == 8'h00;
  assign hyst_filter_halt_o     = h_fhalt_reg;
  assign hyst_filter_always_o   = h_fhalt_reg == 8'h00;
  assign hyst_prox_thresh_o     = h_prox_reg;
  assign hyst_touch_thresh_o    = {h_touch_reg, 2'b00};
  assign prox_thresh_sel_o = guard_active_i ? g_prox_reg
                                            : channel_zero_prox_i;

  shuic_hyst_calc #(.W(10)) u_touch_hyst (
    .thresh_i (hyst_touch_thresh_o),
    .sel_i    (shuic_hyst_t'(hyst_sel_reg[SHUIC_TOUCH_HYST_LSB +: 2])),
    .band_o   (touch_hyst_band_o)
  );
  shuic_hyst_calc #(.W(10)) u_prox_hyst (
    .thresh_i ({2'b00, h_prox_reg}),
    .sel_i    (shuic_hyst_t'(hyst_sel_reg[SHUIC_PROX_HYST_LSB +: 2])),
    .band_o   (prox_hyst_band_o)
  );

  // ==========================================================
  // Half-second tick
  logic [31:0] tick_cnt_reg;
  wire         tick = tick_cnt_reg == 32'(STEP_CYCLES - 1);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) tick_cnt_reg <= 32'h0000_0000;
    else       tick_cnt_reg <= tick ? 32'h0000_0000 : tick_cnt_reg + 1;
  end

  // ==========================================================
  // Movement timeout mode
  // Zero threshold behaviour
  wire zero_qr     = qr_thr_reg == 8'h00;
  wire enter_tmo   = guard_prox_i &&
                     (zero_qr ? cfg_timeout_on_zero_i : quick_release_i);
  logic tmo_reg;
  always_ff @(posedge core_clk_i) begin
    if (rst_i)                        tmo_reg <= 1'b0;
    else if (enter_tmo)               tmo_reg <= 1'b1;
    else if (movement_i || !guard_prox_i) tmo_reg <= 1'b0;
  end
  assign timeout_mode_o = tmo_reg;

  // ==========================================================
  // Average halt timers
  logic [7:0] halt_cnt_reg;
  logic       halt_reg;
  wire        never_exp = qr_time_reg == SHUIC_QR_NEVER_EXPIRE;
  wire [7:0]  halt_len  = tmo_reg ? qr_time_reg
                        : {4'h0, halt_move_reg[7:SHUIC_HALT_TO_LSB]};
  wire        start     = (enter_tmo && !tmo_reg) ||
                          (movement_i && !guard_prox_i);
  wire        expire    = tick && halt_cnt_reg >= halt_len &&
                          !(tmo_reg && never_exp);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      halt_reg     <= 1'b0;
      halt_cnt_reg <= 8'h00;
    end else if (start) begin
      halt_reg     <= 1'b1;
      halt_cnt_reg <= 8'h00;
    end else if (halt_reg && expire) begin
      halt_reg     <= 1'b0;
    end else if (halt_reg && tick && halt_cnt_reg != 8'hFF) begin
      halt_cnt_reg <= halt_cnt_reg + 8'h01;
    end
  end
  assign avg_halt_o = halt_reg;

  // ==========================================================
  // First io pin
  // Standoff or ready select
  wire pin_assert = standoff_to_pin_i ? standoff_i : ready_i;
  assign first_io_pin_o      = 1'b0;
  assign first_io_pin_oe_n_o = !pin_assert;

  // ==========================================================
  // Checks
  hyst_mask_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    we_hs |=> (hyst_sel_reg & ~SHUIC_HYST_WMASK) ==
              $past(hyst_sel_reg & ~SHUIC_HYST_WMASK))
    else $error("reserved select bits changed");
  touch_scale_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    we_ht |=> hyst_touch_thresh_o == {$past(reg_wdata_i), 2'b00})
    else $error("touch threshold not times four");
  prox_sel_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    guard_active_i |-> prox_thresh_sel_o == g_prox_reg)
    else $error("guard prox threshold not used");
  zero_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (zero_qr && !cfg_timeout_on_zero_i && !tmo_reg) |=> !tmo_reg)
    else $error("timeout mode entered with zero threshold");
  zero_enter_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (zero_qr && cfg_timeout_on_zero_i && guard_prox_i) |=> tmo_reg)
    else $error("timeout mode not entered");
  never_exp_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (halt_reg && tmo_reg && never_exp && !movement_i) |=> halt_reg)
    else $error("halt expired with never setting");
  pin_drive_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !first_io_pin_oe_n_o |-> first_io_pin_o == 1'b0)
    else $error("pin driven high");
  pin_route_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    standoff_to_pin_i |-> first_io_pin_oe_n_o == !standoff_i)
    else $error("standoff not on pin");
  filt_zero_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    we_gf && reg_wdata_i == 8'h00 |=> guard_filter_always_o)
    else $error("always halt not flagged");
  cov_tmo_c: cover property (@(posedge core_clk_i) $rose(tmo_reg));
  cov_halt_c: cover property (@(posedge core_clk_i) $fell(halt_reg));
  cov_hs_c: cover property (@(posedge core_clk_i) we_hs);
endmodule : shuic_regs

// File: dv/shuic_host.sv
`timescale 1ns/1ps
// ==========================================================
// Host model on the register port
module shuic_host (
  // Clock
  input  wire logic       core_clk_i,
  // Register port
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_hit_i
);
  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
  end

  // One write pulse, bus scrambled after release
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    #1;
    reg_wr_o    = 1'b1;
    reg_addr_o  = a;
    reg_wdata_o = d;
    @(posedge core_clk_i);
    #1;
    reg_wr_o    = 1'b0;
    reg_addr_o  = ~a;
    reg_wdata_o = ~d;
  endtask : wr

  // One read pulse, data taken the cycle after
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic h);
    @(posedge core_clk_i);
    #1;
    reg_rd_o   = 1'b1;
    reg_addr_o = a;
    #1;
    h = reg_hit_i;
    @(posedge core_clk_i);
    #1;
    reg_rd_o   = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
  endtask : rd
endmodule : shuic_host

// File: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  import shuic_pkg::*;
  logic       core_clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       reg_wr, reg_rd, hit, g_act = 0, g_prox = 0, mov = 0;
  logic       qr = 0, cfg = 0, sel = 0, stand = 0, rdy = 0;
  logic [7:0] addr, wdata, rdata, d;
  logic [7:0] ptsel, qrt, gfh, hfh, hpt;
  logic [3:0] mth;
  logic [9:0] htt, tband, pband;
  logic       gfa, hfa, tmo, halt, pin, pin_oe_n, h;
  int         mismatches = 0;
  int         checked = 0;
  localparam logic [31:0] ROWS [9] = '{
    32'h7125_3C3C, 32'h7205_0000, 32'h7316_0000, 32'h7425_5A5A,
    32'h7528_FFFF, 32'h80A2_FFB3, 32'h810A_0000, 32'h8216_4040,
    32'h8325_FFFF};

  always #20 core_clk_i = ~core_clk_i;

  shuic_host u_host (.core_clk_i(core_clk_i), .reg_wr_o(reg_wr),
    .reg_rd_o(reg_rd), .reg_addr_o(addr), .reg_wdata_o(wdata),
    .reg_rdata_i(rdata), .reg_hit_i(hit));

  shuic_regs #(.STEP_CYCLES(4)) u_dut (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .reg_hit_o(hit), .guard_active_i(g_act), .guard_prox_i(g_prox),
    .movement_i(mov), .quick_release_i(qr),
    .cfg_timeout_on_zero_i(cfg), .standoff_to_pin_i(sel),
    .standoff_i(stand), .ready_i(rdy), .channel_zero_prox_i(8'h33),
    .prox_thresh_sel_o(ptsel), .movement_thresh_o(mth),
    .quick_release_thresh_o(qrt), .guard_filter_halt_o(gfh),
    .guard_filter_always_o(gfa), .hyst_filter_halt_o(hfh),
    .hyst_filter_always_o(hfa), .hyst_prox_thresh_o(hpt),
    .hyst_touch_thresh_o(htt), .touch_hyst_band_o(tband),
    .prox_hyst_band_o(pband), .timeout_mode_o(tmo),
    .avg_halt_o(halt), .first_io_pin_o(pin),
    .first_io_pin_oe_n_o(pin_oe_n));

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  task automatic wait_cyc(int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : wait_cyc

  initial begin
    #400000;
    mismatches++;
    wrap_up;
  end

  initial begin
    logic [7:0] ex;
    wait_cyc(16);
    rst_i = 1'b0;
    // ==========================================================
    // Reset values, write and read back
    foreach (ROWS[i]) begin
      u_host.rd(ROWS[i][31:24], d, h);
      chk("reset value", {8'h00, ROWS[i][23:16]}, {8'h00, d});
      chk("hit", 16'h0001, {15'h0, h});
      u_host.wr(ROWS[i][31:24], ROWS[i][15:8]);
      u_host.rd(ROWS[i][31:24], d, h);
      chk("read back", {8'h00, ROWS[i][7:0]}, {8'h00, d});
    end
    // ==========================================================
    // Derived fields
    chk("movement", 16'h000C, {12'h0, mth});
    chk("qr thresh", 16'h0000, {8'h0, qrt});
    chk("guard halt", 16'h0000, {8'h0, gfh});
    chk("guard always", 16'h0001, {15'h0, gfa});
    chk("hyst halt", 16'h0000, {8'h0, hfh});
    chk("hyst always", 16'h0001, {15'h0, hfa});
    chk("hyst prox", 16'h0040, {8'h0, hpt});
    chk("touch thr", 16'h03FC, {6'h0, htt});
    u_host.wr(8'h81, 8'h01);
    chk("hyst not always", 16'h0000, {15'h0, hfa});
    u_host.rd(8'h76, d, h);
    chk("unmapped data", 16'h0000, {8'h0, d});
    chk("unmapped hit", 16'h0000, {15'h0, h});
    // ==========================================================
    // Hysteresis bands for every selection
    for (int s = 0; s < 4; s++) begin
      u_host.wr(8'h80, {2'b11, s[1:0], 2'b11, s[1:0]});
      u_host.rd(8'h80, d, h);
      ex = 8'h80 | {2'b00, s[1:0], 2'b00, s[1:0]};
      chk("hyst select", {8'h0, ex}, {8'h0, d});
      chk("touch band", (s == 0) ? 16'h0 : 16'h03FC >> (s + 1),
          {6'h0, tband});
      chk("prox band", (s == 0) ? 16'h0 : 16'h0040 >> (s + 1),
          {6'h0, pband});
    end
    // ==========================================================
    // Proximity threshold source and pin
    chk("ch0 prox", 16'h0033, {8'h0, ptsel});
    g_act = 1'b1;
    #1;
    chk("guard prox", 16'h005A, {8'h0, ptsel});
    for (int c = 0; c < 8; c++) begin
      {sel, stand, rdy} = c[2:0];
      wait_cyc(1);
      chk("pin level", 16'h0000, {15'h0, pin});
      chk("pin enable", {15'h0, ~(sel ? stand : rdy)},
          {15'h0, pin_oe_n});
    end
    // ==========================================================
    // Timeout mode and average halt
    g_prox = 1'b1;
    wait_cyc(6);
    chk("no timeout", 16'h0000, {15'h0, tmo});
    cfg = 1'b1;
    wait_cyc(2);
    chk("timeout", 16'h0001, {15'h0, tmo});
    wait_cyc(200);
    chk("halt held", 16'h0001, {15'h0, halt});
    u_host.wr(8'h75, 8'h01);
    wait_cyc(20);
    chk("halt expired", 16'h0000, {15'h0, halt});
    cfg = 1'b0;
    mov = 1'b1;
    wait_cyc(2);
    chk("timeout cleared", 16'h0000, {15'h0, tmo});
    // ==========================================================
    // Second reset
    rst_i = 1'b1;
    wait_cyc(2);
    rst_i = 1'b0;
    u_host.rd(8'h80, d, h);
    chk("reset select", 16'h00A2, {8'h0, d});
    chk("reset touch", 16'h0094, {6'h0, htt});
    // ==========================================================
    // Halt timeout without proximity
    g_prox = 1'b0;
    wait_cyc(2);
    chk("halt start", 16'h0001, {15'h0, halt});
    mov = 1'b0;
    wait_cyc(4);
    chk("halt kept", 16'h0001, {15'h0, halt});
    wait_cyc(12);
    chk("halt timeout", 16'h0000, {15'h0, halt});
    wrap_up;
  end
endmodule : testbench
